// file: hdl/e3om_consts.vh
// Constants for the E3 G.832 receive overhead monitor register bank
//
// Notes on behaviour
// - MA status bits 6:4 show integrated payload type
// - Extraction on: bits 3:0 show integrated timing indicator
// - Extraction off: bit 3 zero, bits 2:0 MA tail
// - NR/GC register bits 15:8 show integrated GC byte
// - NR/GC register bits 7:0 show integrated NR byte
// - Sixteen-bit framing error count is readable
// - Sixteen-bit BIP-8 parity error count is readable
// - Sixteen-bit remote error indication count is readable
// - Counts change only on performance update
`ifndef E3OM_CONSTS_VH
`define E3OM_CONSTS_VH

// Register byte offsets; each register is 16 bits on an even offset
`define E3OM_IDX_MA_FIELDS 8'h30
`define E3OM_IDX_NR_GC 8'h32
`define E3OM_IDX_FRAMING_COUNT 8'h34
`define E3OM_IDX_PARITY_COUNT 8'h36
`define E3OM_IDX_RE_COUNT 8'h38
`define E3OM_IDX_CONTROL 8'h3a
`define E3OM_IDX_STATUS 8'h3c

// Reset values
`define E3OM_RST_STATUS16 16'h0000
`define E3OM_RST_CONTROL 1'b0

// Field positions in the MA status register
`define E3OM_MA_PT_HI 6
`define E3OM_MA_PT_LO 4
`define E3OM_MA_TIMING_HI 3
`define E3OM_MA_TIMING_LO 0

// Field positions in the NR/GC register
`define E3OM_GC_HI 15
`define E3OM_GC_LO 8
`define E3OM_NR_HI 7
`define E3OM_NR_LO 0

// Field positions in the control register
`define E3OM_CTL_TIMING_EXTRACT 0
`define E3OM_CTL_SW_UPDATE 1

// Received MA byte: wire bit 1 is the byte's bit 7
`define E3OM_MA_PT_MSB 5
`define E3OM_MA_PT_LSB 3
`define E3OM_MA_TAIL_MSB 2
`define E3OM_MA_TAIL_LSB 0
`define E3OM_MA_MFI_MSB 2
`define E3OM_MA_MFI_LSB 1
`define E3OM_MA_TIMING_BIT 0

// Integration: identical receipts needed before a value is accepted
`define E3OM_INTEG_COUNT 4'h3
`define E3OM_INTEG_CW 4

// Error counter width
`define E3OM_COUNT_W 16

`endif

// file: hdl/e3om_integrator.v
// Persistence filter that accepts an overhead value seen N times in a row
`timescale 1ns/1ps
`include "e3om_consts.vh"

module e3om_integrator #(
    parameter WIDTH = 8,
    parameter [`E3OM_INTEG_CW-1:0] INTEG_COUNT = `E3OM_INTEG_COUNT
) (
    input wire clk_i,
    input wire rst_i,
    input wire sample_valid_i,
    input wire [WIDTH-1:0] sample_i,
    output reg [WIDTH-1:0] value_o,
    output reg stable_o
);

    reg [WIDTH-1:0] candidate; // Last value seen on the line
    reg [`E3OM_INTEG_CW-1:0] repeat_count; // Receipts of candidate so far

    // A value is published only after it repeats, so a single
    // corrupted frame leaves value_o alone and only clears stable_o
    always @(posedge clk_i) begin
        if (rst_i) begin
            candidate <= {WIDTH{1'b0}};
            repeat_count <= {`E3OM_INTEG_CW{1'b0}};
            value_o <= {WIDTH{1'b0}};
            stable_o <= 1'b0;
        end else if (sample_valid_i) begin
            if (sample_i != candidate) begin
                // New value: restart the persistence count
                candidate <= sample_i;
                repeat_count <= {{(`E3OM_INTEG_CW-1){1'b0}}, 1'b1};
                stable_o <= 1'b0;
            end else if (repeat_count < INTEG_COUNT) begin
                repeat_count <= repeat_count + 1'b1;
            end
            // Publish once the count reaches the threshold
            if ((sample_i == candidate) && (repeat_count + 1'b1 >= INTEG_COUNT)) begin
                value_o <= candidate;
                stable_o <= 1'b1;
            end
        end
    end

endmodule // e3om_integrator

// file: hdl/e3om_rx_overhead_monitor.v
// Receive overhead monitor register bank for an E3 G.832 framer port
`timescale 1ns/1ps
`include "e3om_consts.vh"

module e3om_rx_overhead_monitor #(
    parameter COUNT_W = `E3OM_COUNT_W,
    parameter [`E3OM_INTEG_CW-1:0] INTEG_COUNT = `E3OM_INTEG_COUNT
) (
    input wire clk_i,
    input wire rst_i,
    // Classic Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Overhead bytes from the receive framer, same clock
    input wire ma_valid_i,
    input wire [7:0] ma_byte_i,
    input wire nr_valid_i,
    input wire [7:0] nr_byte_i,
    input wire gc_valid_i,
    input wire [7:0] gc_byte_i,
    // One-cycle error events from the receive framer
    input wire framing_err_i,
    input wire parity_err_i,
    input wire remote_err_i,
    // Performance-monitoring update, arrives from a pin
    input wire perf_monitor_update_i
);

    // ---------------------------------------------------------------
    // Performance-monitoring update synchroniser
    // ---------------------------------------------------------------

    reg upd_meta; // First stage, read only by the second
    reg upd_sync2; // Second stage
    reg upd_sync3; // Third stage
    reg upd_level; // Filtered level, changes when stages agree
    wire upd_edge; // Rising edge of the filtered level

    // Three flops; the level moves only when two and three agree,
    // which rejects a one-cycle glitch on the pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            upd_meta <= 1'b0;
            upd_sync2 <= 1'b0;
            upd_sync3 <= 1'b0;
            upd_level <= 1'b0;
        end else begin
            upd_meta <= perf_monitor_update_i;
            upd_sync2 <= upd_meta;
            upd_sync3 <= upd_sync2;
            if (upd_sync2 == upd_sync3) begin
                upd_level <= upd_sync3;
            end
        end
    end

    // Only the level that has already settled is edge-detected
    assign upd_edge = (upd_sync2 == upd_sync3) && upd_sync3 && !upd_level;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------

    wire bus_req; // Request present and not yet answered
    wire [7:0] reg_index; // Byte offset of the access
    wire word_aligned; // Even offset, naming a 16-bit register
    wire hit_control; // Access targets the control register
    wire bus_write_now; // Write takes effect this edge

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign reg_index = wb_adr_i;
    assign word_aligned = (wb_adr_i[0] == 1'b0);
    assign hit_control = word_aligned && (reg_index == `E3OM_IDX_CONTROL);
    // A write lands at the edge where the master sees ack, never earlier
    assign bus_write_now = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit_control && wb_sel_i[0];

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------

    reg timing_extract_en; // Timing indicator extraction enable
    reg sw_update; // One-cycle update requested by software

    // The software update bit is self-clearing, so a test can freeze
    // the counts without a pin; it always reads back as zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            timing_extract_en <= `E3OM_RST_CONTROL;
            sw_update <= 1'b0;
        end else begin
            sw_update <= 1'b0;
            if (bus_write_now) begin
                timing_extract_en <= wb_dat_i[`E3OM_CTL_TIMING_EXTRACT];
                sw_update <= wb_dat_i[`E3OM_CTL_SW_UPDATE];
            end
        end
    end

    wire perf_update; // Either source of the update event
    assign perf_update = upd_edge || sw_update;

    // ---------------------------------------------------------------
    // MA byte field split and timing indicator assembly
    // ---------------------------------------------------------------

    wire [2:0] ma_payload_type; // MA bits 3 to 5
    wire [2:0] ma_tail; // MA bits 6 to 8
    wire [1:0] ma_frame_pos; // Multiframe position within the tail
    reg [3:0] ind_shadow; // Indicator bits gathered so far
    reg ind_nibble_valid; // Complete indicator nibble this cycle
    reg [3:0] ind_nibble; // Complete indicator nibble

    assign ma_payload_type = ma_byte_i[`E3OM_MA_PT_MSB:`E3OM_MA_PT_LSB];
    assign ma_tail = ma_byte_i[`E3OM_MA_TAIL_MSB:`E3OM_MA_TAIL_LSB];
    assign ma_frame_pos = ma_byte_i[`E3OM_MA_MFI_MSB:`E3OM_MA_MFI_LSB];

    // One indicator bit arrives per frame; the two bits ahead of it
    // number its place, and the fourth place closes the nibble
    always @(posedge clk_i) begin
        if (rst_i) begin
            ind_shadow <= 4'h0;
            ind_nibble <= 4'h0;
            ind_nibble_valid <= 1'b0;
        end else begin
            ind_nibble_valid <= 1'b0;
            if (ma_valid_i) begin
                ind_shadow[ma_frame_pos] <= ma_byte_i[`E3OM_MA_TIMING_BIT];
                if (ma_frame_pos == 2'h3) begin
                    ind_nibble <= {ma_byte_i[`E3OM_MA_TIMING_BIT], ind_shadow[2:0]};
                    ind_nibble_valid <= 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Integrators for the overhead values
    // ---------------------------------------------------------------

    wire [2:0] int_payload_type; // Filtered payload type
    wire [2:0] int_tail; // Filtered MA tail bits
    wire [3:0] int_ind; // Filtered timing indicator nibble
    wire [7:0] int_nr; // Filtered NR byte
    wire [7:0] int_gc; // Filtered GC byte
    wire [4:0] int_stable; // Stability of each filter

    // Payload type from MA bits 3 to 5
    e3om_integrator #(.WIDTH(3), .INTEG_COUNT(INTEG_COUNT)) u_int_pt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_valid_i(ma_valid_i),
        .sample_i(ma_payload_type),
        .value_o(int_payload_type),
        .stable_o(int_stable[0])
    );

    // Raw tail, shown when extraction is off
    e3om_integrator #(.WIDTH(3), .INTEG_COUNT(INTEG_COUNT)) u_int_tail (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_valid_i(ma_valid_i),
        .sample_i(ma_tail),
        .value_o(int_tail),
        .stable_o(int_stable[1])
    );

    // Assembled indicator, shown when extraction is on
    e3om_integrator #(.WIDTH(4), .INTEG_COUNT(INTEG_COUNT)) u_int_ind (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_valid_i(ind_nibble_valid),
        .sample_i(ind_nibble),
        .value_o(int_ind),
        .stable_o(int_stable[2])
    );

    // NR byte
    e3om_integrator #(.WIDTH(8), .INTEG_COUNT(INTEG_COUNT)) u_int_nr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_valid_i(nr_valid_i),
        .sample_i(nr_byte_i),
        .value_o(int_nr),
        .stable_o(int_stable[3])
    );

    // GC byte
    e3om_integrator #(.WIDTH(8), .INTEG_COUNT(INTEG_COUNT)) u_int_gc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_valid_i(gc_valid_i),
        .sample_i(gc_byte_i),
        .value_o(int_gc),
        .stable_o(int_stable[4])
    );

    // ---------------------------------------------------------------
    // Error accumulators and held counts
    // ---------------------------------------------------------------

    wire [2:0] err_event; // Framing, parity, remote
    wire [3*COUNT_W-1:0] held_flat; // Readable counts, packed

    assign err_event = {remote_err_i, parity_err_i, framing_err_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_count
            reg [COUNT_W-1:0] accum; // Running count, not readable
            reg [COUNT_W-1:0] held; // Count software reads
            wire accum_full; // Accumulator saturated

            assign accum_full = &accum;

            // Counts saturate rather than wrap, so a flooded interval
            // reads as the maximum instead of a small misleading number
            always @(posedge clk_i) begin
                if (rst_i) begin
                    accum <= {COUNT_W{1'b0}};
                    held <= {COUNT_W{1'b0}};
                end else if (perf_update) begin
                    // Hand over the interval and restart; an event in
                    // this very cycle opens the next interval
                    held <= accum;
                    accum <= {{(COUNT_W-1){1'b0}}, err_event[gi]};
                end else if (err_event[gi] && !accum_full) begin
                    accum <= accum + 1'b1;
                end
            end

            assign held_flat[gi*COUNT_W +: COUNT_W] = held;
        end
    endgenerate

    // ---------------------------------------------------------------
    // Register views
    // ---------------------------------------------------------------

    wire [3:0] timing_field; // Timing indicator field of the MA register
    wire [15:0] ma_view; // MA status register
    wire [15:0] nr_gc_view; // NR/GC status register
    wire [15:0] framing_view; // Framing error count
    wire [15:0] parity_view; // Parity error count
    wire [15:0] remote_view; // Remote error count

    // With extraction off the top indicator bit reads as zero
    assign timing_field = timing_extract_en ? int_ind : {1'b0, int_tail};

    // Bits 15:7 are reserved and read as zero
    assign ma_view = {9'h000, int_payload_type, timing_field};
    assign nr_gc_view = {int_gc, int_nr};

    assign framing_view = held_flat[0*COUNT_W +: 16];
    assign parity_view = held_flat[1*COUNT_W +: 16];
    assign remote_view = held_flat[2*COUNT_W +: 16];

    // ---------------------------------------------------------------
    // Read multiplexer
    // ---------------------------------------------------------------

    reg [31:0] next_rd_data; // Data for the coming answer

    // Unmapped or misaligned addresses answer with zero data; a read
    // never disturbs any value, so polling is harmless
    always @* begin
        next_rd_data = 32'h0000_0000;
        if (word_aligned) begin
            case (reg_index)
                `E3OM_IDX_MA_FIELDS: begin
                    next_rd_data = {16'h0000, ma_view};
                end
                `E3OM_IDX_NR_GC: begin
                    next_rd_data = {16'h0000, nr_gc_view};
                end
                `E3OM_IDX_FRAMING_COUNT: begin
                    next_rd_data = {16'h0000, framing_view};
                end
                `E3OM_IDX_PARITY_COUNT: begin
                    next_rd_data = {16'h0000, parity_view};
                end
                `E3OM_IDX_RE_COUNT: begin
                    next_rd_data = {16'h0000, remote_view};
                end
                `E3OM_IDX_CONTROL: begin
                    // Update bit is a strobe and reads as zero
                    next_rd_data = {31'h0000_0000, timing_extract_en};
                end
                `E3OM_IDX_STATUS: begin
                    next_rd_data = {26'h000_0000, upd_level, int_stable};
                end
                default: begin
                    next_rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Wishbone answer
    // ---------------------------------------------------------------

    // Every access is answered one cycle after it is seen; ack falls
    // the cycle after, so back-to-back cycles see a clean gap
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rd_data;
            end
        end
    end

endmodule // e3om_rx_overhead_monitor

// file: tb/e3om_rx_overhead_monitor_props.sv
// Checker for the receive overhead monitor register bank
`timescale 1ns/1ps

module e3om_rx_props (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire perf_monitor_update_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic pin_q; // Previous pin level
    logic [7:0] chg; // Update causes seen so far
    logic [7:0] chg_last; // Update causes at the last count read
    logic [15:0] framing_last; // Framing count at the last read
    logic framing_valid; // A framing count read has been seen
    wire rd_ack = wb_ack_o && !wb_we_i; // Read answer
    wire framing_rd = rd_ack && wb_adr_i == 8'h34; // Framing count answer

    // Track update causes; a software update counts as one too
    always @(posedge clk_i) begin
        pin_q <= perf_monitor_update_i;
        if (rst_i) begin
            chg <= 8'h00;
            framing_valid <= 1'b0;
        end else begin
            if (pin_q != perf_monitor_update_i || (wb_ack_o && wb_we_i && wb_adr_i == 8'h3a)) begin
                chg <= chg + 8'h01;
            end
            if (framing_rd) begin
                framing_valid <= 1'b1;
                framing_last <= wb_dat_o[15:0];
                chg_last <= chg;
            end
        end
    end

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_half_zero: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0000) else $error("upper half not zero");
    a_ma_top_zero: assert property (rd_ack && wb_adr_i == 8'h30 |-> wb_dat_o[15:7] == 9'h000)
        else $error("unused MA bits set");
    a_unmapped_zero: assert property (rd_ack && (wb_adr_i[0] != 1'b0 || wb_adr_i < 8'h30 || wb_adr_i > 8'h3c)
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_count_holds: assert property (framing_rd && framing_valid && chg == chg_last |-> wb_dat_o[15:0] == framing_last)
        else $error("framing count moved without update");
    a_reset_clears: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0)
        else $error("reset did not clear bus outputs");

    c_read: cover property (rd_ack);
    c_write: cover property (wb_ack_o && wb_we_i);
    c_pin_update: cover property ($rose(perf_monitor_update_i));
endmodule // e3om_rx_props

bind e3om_rx_overhead_monitor e3om_rx_props u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .perf_monitor_update_i(perf_monitor_update_i)
);

// file: tb/e3om_host_model.sv
// Host processor model: classic Wishbone master for register access
`timescale 1ns/1ps

module e3om_host_model (
    input wire clk_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire [31:0] dat_i,
    input wire ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One classic cycle; ack and data are the values sampled at the edge
    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= 4'hf;
        dat_o <= wd;
        // Hold everything until ack is seen high; only the bench timeout ends this
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // Idle a cycle so the next request never lands on the release edge
        @(posedge clk_i);
    endtask
endmodule // e3om_host_model

// file: tb/tb_top.sv
// Testbench for the receive overhead monitor register bank
`timescale 1ns/1ps

module tb_top;
    localparam int INTEG = 3; // Identical receipts needed before a value shows
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ma_valid = 1'b0, nr_valid = 1'b0, gc_valid = 1'b0;
    logic [7:0] ma_byte = 8'h00, nr_byte = 8'h00, gc_byte = 8'h00;
    logic framing_err = 1'b0, parity_err = 1'b0, remote_err = 1'b0, update_pin = 1'b0;
    wire cyc, stb, we, ack;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat, rdat;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    always #12.5 clk_i = ~clk_i;

    e3om_rx_overhead_monitor #(.INTEG_COUNT(4'h3)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ma_valid_i(ma_valid),
        .ma_byte_i(ma_byte), .nr_valid_i(nr_valid), .nr_byte_i(nr_byte), .gc_valid_i(gc_valid),
        .gc_byte_i(gc_byte), .framing_err_i(framing_err), .parity_err_i(parity_err), .remote_err_i(remote_err),
        .perf_monitor_update_i(update_pin));

    e3om_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Ceiling well above the roughly two hundred cycles the scenarios need
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t run timed out", $time);
            stop_test();
        end
    end

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        host.access(1'b0, a, 32'h0, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t read at %h gave %h, expected %h", $time, a, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        host.access(1'b1, a, d, unused);
    endtask

    // One framer strobe cycle per call, then a quiet cycle
    task automatic send(input logic m, input logic n, input logic g, input logic [7:0] b);
        @(posedge clk_i);
        ma_valid <= m;
        nr_valid <= n;
        gc_valid <= g;
        ma_byte <= b;
        nr_byte <= b;
        gc_byte <= ~b;
        @(posedge clk_i);
        ma_valid <= 1'b0;
        nr_valid <= 1'b0;
        gc_valid <= 1'b0;
        ma_byte <= ~b;
        nr_byte <= ~b;
        gc_byte <= b;
    endtask

    task automatic pulse_errs(input int nf, input int np, input int nr);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            framing_err <= (i < nf);
            parity_err <= (i < np);
            remote_err <= (i < nr);
            @(posedge clk_i);
            framing_err <= 1'b0;
            parity_err <= 1'b0;
            remote_err <= 1'b0;
        end
    endtask

    task automatic test_reset_and_map();
        chk_reg(8'h30, 32'h0);
        chk_reg(8'h32, 32'h0);
        chk_reg(8'h34, 32'h0);
        chk_reg(8'h36, 32'h0);
        chk_reg(8'h38, 32'h0);
        wr(8'h34, 32'h0000ffff);
        chk_reg(8'h34, 32'h0);
        chk_reg(8'hfc, 32'h0);
        chk_reg(8'h31, 32'h0);
    endtask

    task automatic test_overhead();
        // Extraction off: top bit of the timing field forced low, top MA bits ignored
        repeat (INTEG) send(1'b1, 1'b1, 1'b1, 8'hde);
        repeat (4) @(posedge clk_i);
        chk_reg(8'h30, 32'h00000036);
        chk_reg(8'h32, 32'h000021de);
        // Extraction on: nibble 1010 assembled over four positions, payload type 101
        wr(8'h3a, 32'h00000001);
        repeat (INTEG) for (int p = 0; p < 4; p++) send(1'b1, 1'b0, 1'b0, {2'b01, 3'b101, p[1:0], p[0]});
        repeat (4) @(posedge clk_i);
        chk_reg(8'h30, 32'h0000005a);
        chk_reg(8'h3a, 32'h00000001);
        // Payload, indicator, NR and GC settled; the changing tail is not
        chk_reg(8'h3c, 32'h0000001d);
    endtask

    task automatic test_counts();
        pulse_errs(3, 5, 7);
        chk_reg(8'h34, 32'h0);
        @(posedge clk_i);
        update_pin <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk_reg(8'h34, 32'h3);
        chk_reg(8'h36, 32'h5);
        chk_reg(8'h38, 32'h7);
        chk_reg(8'h3c, 32'h0000003d);
        // Second interval starts from zero and ends on a software update
        pulse_errs(2, 0, 1);
        chk_reg(8'h34, 32'h3);
        wr(8'h3a, 32'h00000003);
        repeat (4) @(posedge clk_i);
        chk_reg(8'h34, 32'h2);
        chk_reg(8'h36, 32'h0);
        chk_reg(8'h38, 32'h1);
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_and_map();
        test_overhead();
        test_counts();
        stop_test();
    end
endmodule // tb_top
